// ===== hdl/iasc_core.sv
// Indirect addressing, program counter low, table and flags core
// Operation
// (RQ1) Indirect window accesses go to pointed location
// (RQ2) Window zero sector 0; others any sector
// (RQ3) High pointer gives sector, low gives location
// (RQ4) Window aimed at window: read 00H, write ignored
// (RQ5) Pointers are real read/write storage
// (RQ6) Extended direct access reaches every sector
// (RQ7) Program counter low write jumps within page
// (RQ8) Program counter low change inserts dummy cycle
// (RQ9) Table read: high byte kept, low to destination
// (RQ10) ALU results land in accumulator; the core does so only when dest_mem is clear, else the result goes to memory
// (RQ11) Flags writes keep watchdog and sleep bits
// (RQ12) Watchdog bit: timeout sets, clear/sleep/reset clear
// (RQ13) Sleep bit: sleep sets, clear/reset clear
// (RQ14) Sign flag is wrap xor result MSB
// (RQ15) Plain subtract copies zero to chained zero
// (RQ16) Borrow subtract ANDs chained zero with zero
// (RQ17) Other operations keep chained zero
// (RQ18) Carry from add, no-borrow, or rotate
// (RQ19) Nibble carry from low nibble
// (RQ20) Zero flag marks zero result; the core keeps the old zero flag on both rotates
// (RQ21) Wrap flag: carry in differs from out
// (RQ22) Software saves flags around calls itself
// (RQ23) Pointer step touches only that pointer
`timescale 1ns/1ps
`include "iasc_consts.svh"
module iasc_core #(
  parameter int SW   = `IASC_SEC_W,
  parameter int PC_W = `IASC_PC_W
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // Requests from the instruction decoder
  input  wire iasc_pkg::iasc_mem_req_type mem_req_i,
  input  wire iasc_pkg::iasc_alu_req_type alu_req_i,
  input  wire iasc_pkg::iasc_sys_evt_type sys_evt_i,
  input  wire logic                     pc_step_i,
  input  wire logic                     tbl_read_i,
  input  wire logic [15:0]              tbl_word_i,
  // Answers and state
  output logic                          rd_valid_o,
  output logic [7:0]                    rd_data_o,
  output logic [7:0]                    acc_o,
  output logic [7:0]                    flags_o,
  output logic [PC_W-1:0]               pc_o,
  output logic [15:0]                   tbl_addr_o,
  output logic                          dummy_cycle_o
);

  // Pointer and table storage
  logic [7:0] pointer_sector_zero;
  logic [7:0] pointer_a_low;
  logic [7:0] pointer_a_high;
  logic [7:0] pointer_b_low;
  logic [7:0] pointer_b_high;
  logic [7:0] table_high_byte;

  // Write path
  logic                   wr_en;
  logic [7:0]             wr_data;
  iasc_pkg::iasc_loc_type wr_loc;
  logic                   sfr_wr;
  logic                   ram_we;

  // Read path
  iasc_pkg::iasc_loc_type rd_loc;
  logic                   rd_v1;
  logic                   rd_ind1;
  logic                   rd_sfr1;
  logic [7:0]             sfr_val1;
  logic [7:0]             ram_q;

  // ALU
  logic [7:0] alu_res;
  logic [7:0] alu_bx;
  logic       alu_cin;
  logic       alu_arith;
  logic [4:0] sum_lo;
  logic [7:0] sum_mid;
  logic [8:0] sum_all;
  logic [7:0] next_flags;

  // Window offsets
  function automatic logic is_ind(input logic [7:0] a);
    return (a == `IASC_OFS_IND0) || (a == `IASC_OFS_IND1) ||
           (a == `IASC_OFS_IND2);
  endfunction

  // Special register region, present in every sector
  function automatic logic is_sfr(input logic [7:0] a);
    return a < `IASC_SFR_END;
  endfunction

  // Turn a named address into the location really touched
  function automatic iasc_pkg::iasc_loc_type resolve(
    input logic          ext,
    input logic [SW-1:0] sec,
    input logic [7:0]    a
  );
    iasc_pkg::iasc_loc_type l;
    l.sector = ext ? sec : '0; // RQ6
    l.addr   = a;
    l.ind    = 1'b0;
    case (a)
      `IASC_OFS_IND0: begin
        l.sector = '0; // RQ2
        l.addr   = pointer_sector_zero; // RQ1
      end
      `IASC_OFS_IND1: begin
        l.sector = pointer_a_high[SW-1:0]; // RQ3
        l.addr   = pointer_a_low;
      end
      `IASC_OFS_IND2: begin
        l.sector = pointer_b_high[SW-1:0]; // RQ3
        l.addr   = pointer_b_low;
      end
      default: begin
      end
    endcase
    l.ind = is_ind(a) && is_ind(l.addr); // RQ4
    return l;
  endfunction

  // Current value of a special register
  function automatic logic [7:0] sfr_read(input logic [7:0] a);
    case (a)
      `IASC_OFS_PTR0: return pointer_sector_zero;
      `IASC_OFS_PA_L: return pointer_a_low;
      `IASC_OFS_PA_H: return pointer_a_high;
      `IASC_OFS_PB_L: return pointer_b_low;
      `IASC_OFS_PB_H: return pointer_b_high;
      `IASC_OFS_ACC:  return acc_o;
      `IASC_OFS_PCLO: return pc_o[7:0];
      `IASC_OFS_TB_L: return tbl_addr_o[7:0];
      `IASC_OFS_TB_H: return tbl_addr_o[15:8];
      `IASC_OFS_TB_B: return table_high_byte;
      `IASC_OFS_FLG:  return flags_o;
      default:        return `IASC_IND_READ;
    endcase
  endfunction

  // ALU datapath
  always_comb begin
    alu_arith = 1'b1;
    alu_bx    = alu_req_i.operand;
    alu_cin   = 1'b0;
    case (alu_req_i.op)
      iasc_pkg::iasc_op_add_carry: alu_cin = flags_o[`IASC_FLG_CARRY];
      iasc_pkg::iasc_op_sub: begin
        alu_bx  = ~alu_req_i.operand;
        alu_cin = 1'b1;
      end
      iasc_pkg::iasc_op_minus_borrow: begin
        alu_bx  = ~alu_req_i.operand;
        alu_cin = flags_o[`IASC_FLG_CARRY];
      end
      iasc_pkg::iasc_op_add: alu_cin = 1'b0;
      default: alu_arith = 1'b0;
    endcase
    sum_lo  = {1'b0, acc_o[3:0]} + {1'b0, alu_bx[3:0]} + {4'h0, alu_cin};
    sum_mid = {1'b0, acc_o[6:0]} + {1'b0, alu_bx[6:0]} + {7'h00, alu_cin};
    sum_all = {1'b0, acc_o} + {1'b0, alu_bx} + {8'h00, alu_cin};
    case (alu_req_i.op)
      iasc_pkg::iasc_op_and:       alu_res = acc_o & alu_req_i.operand;
      iasc_pkg::iasc_op_or:        alu_res = acc_o | alu_req_i.operand;
      iasc_pkg::iasc_op_xor:       alu_res = acc_o ^ alu_req_i.operand;
      iasc_pkg::iasc_op_rot_left:
        alu_res = {alu_req_i.operand[6:0], flags_o[`IASC_FLG_CARRY]};
      iasc_pkg::iasc_op_rot_right:
        alu_res = {flags_o[`IASC_FLG_CARRY], alu_req_i.operand[7:1]};
      default:                     alu_res = sum_all[7:0];
    endcase
  end

  // Pick the write source; ALU memory results win over moves
  always_comb begin
    wr_en   = 1'b0;
    wr_data = alu_res;
    wr_loc  = resolve(alu_req_i.ext, alu_req_i.sector, alu_req_i.addr);
    if (alu_req_i.valid && alu_req_i.dest_mem) begin
      wr_en = 1'b1;
    end else if (mem_req_i.valid && mem_req_i.write) begin
      wr_en   = 1'b1;
      wr_loc  = resolve(mem_req_i.ext, mem_req_i.sector, mem_req_i.addr);
      wr_data = tbl_read_i ? tbl_word_i[7:0] : mem_req_i.wdata; // RQ9
    end
    sfr_wr = wr_en && !wr_loc.ind && is_sfr(wr_loc.addr); // RQ4
    ram_we = wr_en && !wr_loc.ind && !is_sfr(wr_loc.addr); // RQ1
  end

  // Location named by a read; a process so pointer changes re-resolve it
  always_comb begin
    rd_loc = resolve(mem_req_i.ext, mem_req_i.sector, mem_req_i.addr);
  end

  // Data memory behind the windows
  iasc_data_ram #(
    .AW(SW + 8),
    .DW(8)
  ) u_ram (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .we_i   (ram_we),
    .waddr_i({wr_loc.sector, wr_loc.addr}),
    .wdata_i(wr_data),
    .raddr_i({rd_loc.sector, rd_loc.addr}),
    .rdata_o(ram_q)
  );

  // Memory pointers, plain 8-bit storage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pointer_sector_zero <= `IASC_REG_RST;
      pointer_a_low       <= `IASC_REG_RST;
      pointer_a_high      <= `IASC_REG_RST;
      pointer_b_low       <= `IASC_REG_RST;
      pointer_b_high      <= `IASC_REG_RST;
    end else if (sfr_wr) begin
      case (wr_loc.addr) // RQ5 RQ23
        `IASC_OFS_PTR0: pointer_sector_zero <= wr_data;
        `IASC_OFS_PA_L: pointer_a_low       <= wr_data;
        `IASC_OFS_PA_H: pointer_a_high      <= wr_data;
        `IASC_OFS_PB_L: pointer_b_low       <= wr_data;
        `IASC_OFS_PB_H: pointer_b_high      <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Accumulator
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_o <= `IASC_REG_RST;
    end else if (sfr_wr && wr_loc.addr == `IASC_OFS_ACC) begin
      acc_o <= wr_data;
    end else if (alu_req_i.valid && !alu_req_i.dest_mem) begin
      acc_o <= alu_res; // RQ10
    end
  end

  // Table pointers and fetched high byte
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tbl_addr_o      <= {`IASC_REG_RST, `IASC_REG_RST};
      table_high_byte <= `IASC_REG_RST;
    end else begin
      if (sfr_wr && wr_loc.addr == `IASC_OFS_TB_L) begin
        tbl_addr_o[7:0] <= wr_data;
      end
      if (sfr_wr && wr_loc.addr == `IASC_OFS_TB_H) begin
        tbl_addr_o[15:8] <= wr_data;
      end
      if (tbl_read_i) begin
        table_high_byte <= tbl_word_i[15:8]; // RQ9
      end else if (sfr_wr && wr_loc.addr == `IASC_OFS_TB_B) begin
        table_high_byte <= wr_data;
      end
    end
  end

  // Program counter and dummy cycle after a low byte change
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pc_o          <= '0;
      dummy_cycle_o <= 1'b0;
    end else begin
      dummy_cycle_o <= sfr_wr && wr_loc.addr == `IASC_OFS_PCLO; // RQ8
      if (sfr_wr && wr_loc.addr == `IASC_OFS_PCLO) begin
        pc_o <= {pc_o[PC_W-1:8], wr_data}; // RQ7
      end else if (pc_step_i) begin
        pc_o <= pc_o + 1'b1;
      end
    end
  end

  // Flag update: ALU, then software write, then system events
  always_comb begin
    next_flags = flags_o;
    if (alu_req_i.valid) begin
      next_flags[`IASC_FLG_ZERO] = (alu_res == 8'h00); // RQ20
      if (alu_arith) begin
        next_flags[`IASC_FLG_CARRY] = sum_all[8]; // RQ18
        next_flags[`IASC_FLG_NIB]   = sum_lo[4]; // RQ19
        next_flags[`IASC_FLG_WRAP]  = sum_mid[7] ^ sum_all[8]; // RQ21
      end
      if (alu_req_i.op == iasc_pkg::iasc_op_rot_left) begin
        next_flags[`IASC_FLG_CARRY] = alu_req_i.operand[7]; // RQ18
        next_flags[`IASC_FLG_ZERO]  = flags_o[`IASC_FLG_ZERO];
      end
      if (alu_req_i.op == iasc_pkg::iasc_op_rot_right) begin
        next_flags[`IASC_FLG_CARRY] = alu_req_i.operand[0]; // RQ18
        next_flags[`IASC_FLG_ZERO]  = flags_o[`IASC_FLG_ZERO];
      end
      next_flags[`IASC_FLG_SIGN] = next_flags[`IASC_FLG_WRAP] ^ alu_res[7]; // RQ14
      case (alu_req_i.op) // RQ17
        iasc_pkg::iasc_op_sub:
          next_flags[`IASC_FLG_CHZ] = next_flags[`IASC_FLG_ZERO]; // RQ15
        iasc_pkg::iasc_op_minus_borrow:
          next_flags[`IASC_FLG_CHZ] = flags_o[`IASC_FLG_CHZ] &
                                      next_flags[`IASC_FLG_ZERO]; // RQ16
        default: begin
        end
      endcase
    end
    if (sfr_wr && wr_loc.addr == `IASC_OFS_FLG) begin
      next_flags = (wr_data & `IASC_FLG_WMASK) |
                   (next_flags & ~`IASC_FLG_WMASK); // RQ11
    end
    if (sys_evt_i.wdog_expire) begin
      next_flags[`IASC_FLG_WDOG] = 1'b1; // RQ12
    end else if (sys_evt_i.wdog_clear || sys_evt_i.sleep) begin
      next_flags[`IASC_FLG_WDOG] = 1'b0; // RQ12
    end
    if (sys_evt_i.sleep) begin
      next_flags[`IASC_FLG_SLEEP] = 1'b1; // RQ13
    end else if (sys_evt_i.wdog_clear) begin
      next_flags[`IASC_FLG_SLEEP] = 1'b0; // RQ13
    end
  end

  // Flags register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_o <= `IASC_FLG_RST; // RQ12 RQ13
    end else begin
      flags_o <= next_flags;
    end
  end

  // Read pipeline, first stage beside the array read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_v1    <= 1'b0;
      rd_ind1  <= 1'b0;
      rd_sfr1  <= 1'b0;
      sfr_val1 <= `IASC_REG_RST;
    end else begin
      rd_v1    <= mem_req_i.valid && !mem_req_i.write;
      rd_ind1  <= rd_loc.ind;
      rd_sfr1  <= is_sfr(rd_loc.addr);
      sfr_val1 <= sfr_read(rd_loc.addr);
    end
  end

  // Read answer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= `IASC_REG_RST;
    end else begin
      rd_valid_o <= rd_v1;
      rd_data_o  <= rd_ind1 ? `IASC_IND_READ : // RQ4
                    (rd_sfr1 ? sfr_val1 : ram_q);
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic flg_quiet;
  assign flg_quiet = !(sfr_wr && wr_loc.addr == `IASC_OFS_FLG);

  sequence s_pcl_jump;
    sfr_wr && wr_loc.addr == `IASC_OFS_PCLO;
  endsequence

  sequence s_dummy_then_run;
    dummy_cycle_o ##1 (!dummy_cycle_o || $past(sfr_wr && wr_loc.addr == `IASC_OFS_PCLO));
  endsequence

  AST_IND_READ_ZERO: assert property ( // RQ4
    mem_req_i.valid && !mem_req_i.write && rd_loc.ind
    |-> ##2 rd_valid_o && rd_data_o == 8'h00)
    else $error("window aimed at window read not zero");

  AST_IND0_SECTOR: assert property ( // RQ2
    mem_req_i.valid && mem_req_i.addr == `IASC_OFS_IND0 |-> rd_loc.sector == '0)
    else $error("window zero left sector 0");

  AST_IND1_TARGET: assert property ( // RQ3
    mem_req_i.valid && mem_req_i.addr == `IASC_OFS_IND1 |->
    rd_loc.addr == pointer_a_low && rd_loc.sector == pointer_a_high[SW-1:0])
    else $error("window one not steered by pointer pair");

  AST_PTR_STORE: assert property ( // RQ5
    sfr_wr && wr_loc.addr == `IASC_OFS_PTR0 |=> pointer_sector_zero == $past(wr_data))
    else $error("pointer write lost");

  AST_PCL_JUMP: assert property ( // RQ7
    s_pcl_jump |=> pc_o[7:0] == $past(wr_data) &&
    pc_o[PC_W-1:8] == $past(pc_o[PC_W-1:8]))
    else $error("low byte jump wrong");

  AST_PCL_DUMMY: assert property ( // RQ8
    s_pcl_jump |=> s_dummy_then_run)
    else $error("no single dummy cycle");

  AST_ACC_RESULT: assert property ( // RQ10
    alu_req_i.valid && !alu_req_i.dest_mem && !(sfr_wr && wr_loc.addr == `IASC_OFS_ACC)
    |=> acc_o == $past(alu_res) ##1 rd_valid_o == $past(rd_v1))
    else $error("ALU result missing from accumulator");

  AST_FLG_PROTECT: assert property ( // RQ11
    !flg_quiet && sys_evt_i == '0 |=> $stable(flags_o[5:4]))
    else $error("flags write touched protected bits");

  AST_WDOG_SET: assert property ( // RQ12
    sys_evt_i.wdog_expire |=> flags_o[`IASC_FLG_WDOG])
    else $error("watchdog bit not set");

  AST_SLEEP_SET: assert property ( // RQ13
    sys_evt_i.sleep && !sys_evt_i.wdog_expire
    |=> flags_o[`IASC_FLG_SLEEP] && !flags_o[`IASC_FLG_WDOG])
    else $error("sleep flags wrong");

  AST_SIGN: assert property ( // RQ14
    alu_req_i.valid && flg_quiet |=>
    flags_o[`IASC_FLG_SIGN] == (flags_o[`IASC_FLG_WRAP] ^ $past(alu_res[7])))
    else $error("sign flag mismatch");

  AST_CHZ_SUB: assert property ( // RQ15
    alu_req_i.valid && alu_req_i.op == iasc_pkg::iasc_op_sub && flg_quiet
    |=> flags_o[`IASC_FLG_CHZ] == flags_o[`IASC_FLG_ZERO])
    else $error("chained zero not copied");

  AST_CHZ_BORROW: assert property ( // RQ16
    alu_req_i.valid && alu_req_i.op == iasc_pkg::iasc_op_minus_borrow && flg_quiet
    |=> flags_o[`IASC_FLG_CHZ] ==
        ($past(flags_o[`IASC_FLG_CHZ]) && flags_o[`IASC_FLG_ZERO]))
    else $error("chained zero not ANDed");

  AST_ADD_CARRY: assert property ( // RQ18
    alu_req_i.valid && alu_req_i.op == iasc_pkg::iasc_op_add && flg_quiet
    |=> flags_o[`IASC_FLG_CARRY] ==
        ({1'b0, $past(acc_o)} + {1'b0, $past(alu_req_i.operand)} > 9'h0FF))
    else $error("add carry wrong");

endmodule

// ===== hdl/iasc_consts.svh
// Offsets, flag positions, reset values and widths of the core
`ifndef IASC_CONSTS_SVH
`define IASC_CONSTS_SVH

// Widths
`define IASC_SEC_W    2
`define IASC_PC_W     13

// Special register offsets, mirrored in every sector
`define IASC_OFS_IND0 8'h00
`define IASC_OFS_PTR0 8'h01
`define IASC_OFS_IND1 8'h02
`define IASC_OFS_PA_L 8'h03
`define IASC_OFS_PA_H 8'h04
`define IASC_OFS_ACC  8'h05
`define IASC_OFS_PCLO 8'h06
`define IASC_OFS_TB_L 8'h07
`define IASC_OFS_IND2 8'h08
`define IASC_OFS_PB_L 8'h09
`define IASC_OFS_PB_H 8'h0A
`define IASC_OFS_FLG  8'h0B
`define IASC_OFS_TB_H 8'h0C
`define IASC_OFS_TB_B 8'h0D
`define IASC_SFR_END  8'h0E

// Flag bit positions
`define IASC_FLG_CARRY 0
`define IASC_FLG_NIB   1
`define IASC_FLG_ZERO  2
`define IASC_FLG_WRAP  3
`define IASC_FLG_SLEEP 4
`define IASC_FLG_WDOG  5
`define IASC_FLG_CHZ   6
`define IASC_FLG_SIGN  7

// Reset values and masks
`define IASC_FLG_RST   8'h00
`define IASC_REG_RST   8'h00
`define IASC_FLG_WMASK 8'hCF
`define IASC_IND_READ  8'h00

`endif

// ===== hdl/iasc_pkg.sv
// Types shared by the indirect addressing and status core
`include "iasc_consts.svh"
package iasc_pkg;

  // Operations the core ALU performs
  typedef enum logic [3:0] {
    iasc_op_add          = 4'h0,
    iasc_op_add_carry    = 4'h1,
    iasc_op_sub          = 4'h2,
    iasc_op_minus_borrow = 4'h3,
    iasc_op_and          = 4'h4,
    iasc_op_or           = 4'h5,
    iasc_op_xor          = 4'h6,
    iasc_op_rot_left     = 4'h7,
    iasc_op_rot_right    = 4'h8
  } iasc_op_type;

  // Data memory access from the decoder
  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic                   ext;
    logic [`IASC_SEC_W-1:0] sector;
    logic [7:0]             addr;
    logic [7:0]             wdata;
  } iasc_mem_req_type;

  // ALU request, operand b and optional memory destination
  typedef struct packed {
    logic                   valid;
    iasc_op_type            op;
    logic                   dest_mem;
    logic                   ext;
    logic [`IASC_SEC_W-1:0] sector;
    logic [7:0]             addr;
    logic [7:0]             operand;
  } iasc_alu_req_type;

  // System events from the watchdog and power control
  typedef struct packed {
    logic wdog_expire;
    logic wdog_clear;
    logic sleep;
  } iasc_sys_evt_type;

  // Resolved data memory location
  typedef struct packed {
    logic [`IASC_SEC_W-1:0] sector;
    logic [7:0]             addr;
    logic                   ind;
  } iasc_loc_type;

endpackage

// ===== hdl/iasc_data_ram.sv
// Data memory array with registered read data
`timescale 1ns/1ps
module iasc_data_ram #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // Read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Array write
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

// ===== testbench/iasc_exec_model.sv
// Behavioural decoder and ALU front end that drives the core
`timescale 1ns/1ps
module iasc_exec_model (
  // Clock
  input  wire logic                  clk_i,
  // Requests to the core
  output iasc_pkg::iasc_mem_req_type mem_req_o,
  output iasc_pkg::iasc_alu_req_type alu_req_o,
  output iasc_pkg::iasc_sys_evt_type sys_evt_o,
  output logic                       pc_step_o,
  output logic                       tbl_read_o,
  output logic [15:0]                tbl_word_o,
  // Answers from the core
  input  wire logic                  rd_valid_i,
  input  wire logic [7:0]            rd_data_i,
  input  wire logic [15:0]           tbl_addr_i
);
  // Program memory: word pattern changes with every address
  assign tbl_word_o = {tbl_addr_i[7:0] ^ 8'hA5, tbl_addr_i[15:8] ^ 8'h3C};

  // Idle requests from time zero
  initial begin
    mem_req_o  = '0;
    alu_req_o  = '0;
    sys_evt_o  = '0;
    pc_step_o  = 1'b0;
    tbl_read_o = 1'b0;
  end

  // Memory write, optionally carrying a table word
  task automatic wr(input logic [1:0] s, input logic [7:0] a, input logic [7:0] d,
                    input logic tbl);
    @(posedge clk_i);
    mem_req_o  <= '{1'b1, 1'b1, 1'b1, s, a, d};
    tbl_read_o <= tbl;
    @(posedge clk_i);
    mem_req_o.valid <= 1'b0;
    tbl_read_o      <= 1'b0;
    #1;
  endtask

  // Memory read, bounded wait for the answer
  task automatic rd(input logic [1:0] s, input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_i);
    mem_req_o <= '{1'b1, 1'b0, 1'b1, s, a, 8'h00};
    @(posedge clk_i);
    mem_req_o.valid <= 1'b0;
    d = 'x;
    n = 0;
    while (n < 4) begin
      @(posedge clk_i);
      #1;
      if (rd_valid_i === 1'b1) begin
        d = rd_data_i;
        n = 4;
      end
      n++;
    end
  endtask

  // One ALU operation, optional memory destination
  task automatic alu(input iasc_pkg::iasc_op_type op, input logic [7:0] b,
                     input logic dm, input logic [7:0] a);
    @(posedge clk_i);
    alu_req_o <= '{1'b1, op, dm, 1'b0, 2'h0, a, b};
    @(posedge clk_i);
    alu_req_o.valid <= 1'b0;
    #1;
  endtask

  // One-cycle system event pulse
  task automatic evt(input iasc_pkg::iasc_sys_evt_type e);
    @(posedge clk_i);
    sys_evt_o <= e;
    @(posedge clk_i);
    sys_evt_o <= '0;
    #1;
  endtask

  // Program counter steps, one per cycle
  task automatic step(input int n);
    @(posedge clk_i);
    pc_step_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    pc_step_o <= 1'b0;
    #1;
  endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the indirect addressing and status core
`timescale 1ns/1ps
`include "iasc_consts.svh"
`define CHK(act, exp) begin \
  check_count++; \
  if ((act) !== (exp)) begin \
    bad_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (act), (exp)); \
  end \
end
module tb_top;
  typedef struct {
    iasc_pkg::iasc_op_type op;
    logic [7:0]            f0, a, b, r, f;
  } iasc_vec_type;

  logic                       clk_i;
  logic                       rst_n_i;
  iasc_pkg::iasc_mem_req_type mem_req;
  iasc_pkg::iasc_alu_req_type alu_req;
  iasc_pkg::iasc_sys_evt_type sys_evt;
  logic                       pc_step;
  logic                       tbl_read;
  logic [15:0]                tbl_word;
  logic                       rd_valid;
  logic [7:0]                 rd_data;
  logic [7:0]                 acc;
  logic [7:0]                 flags;
  logic [12:0]                pc;
  logic [15:0]                tbl_addr;
  logic                       dummy;
  logic [7:0]                 saved;
  int                         bad_count;
  int                         check_count;

  // Start flags, acc, operand, result, flags after
  iasc_vec_type vecs [11] = '{
    '{iasc_pkg::iasc_op_add,          8'h00, 8'h7F, 8'h01, 8'h80, 8'h0A},
    '{iasc_pkg::iasc_op_add_carry,    8'h01, 8'h0F, 8'h00, 8'h10, 8'h02},
    '{iasc_pkg::iasc_op_sub,          8'h00, 8'h05, 8'h05, 8'h00, 8'h47},
    '{iasc_pkg::iasc_op_minus_borrow, 8'h41, 8'h03, 8'h03, 8'h00, 8'h47},
    '{iasc_pkg::iasc_op_minus_borrow, 8'h01, 8'h03, 8'h03, 8'h00, 8'h07},
    '{iasc_pkg::iasc_op_minus_borrow, 8'h40, 8'h03, 8'h03, 8'hFF, 8'h80},
    '{iasc_pkg::iasc_op_and,          8'h49, 8'hF0, 8'h0F, 8'h00, 8'hCD},
    '{iasc_pkg::iasc_op_or,           8'h00, 8'h80, 8'h01, 8'h81, 8'h80},
    '{iasc_pkg::iasc_op_xor,          8'h00, 8'hFF, 8'hFF, 8'h00, 8'h04},
    '{iasc_pkg::iasc_op_rot_left,     8'h00, 8'h80, 8'h80, 8'h00, 8'h01},
    '{iasc_pkg::iasc_op_rot_right,    8'h01, 8'h01, 8'h01, 8'h80, 8'h81}
  };

  // Design and decoder model
  iasc_core u_iasc_core (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mem_req_i(mem_req), .alu_req_i(alu_req),
    .sys_evt_i(sys_evt), .pc_step_i(pc_step), .tbl_read_i(tbl_read),
    .tbl_word_i(tbl_word), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .acc_o(acc),
    .flags_o(flags), .pc_o(pc), .tbl_addr_o(tbl_addr), .dummy_cycle_o(dummy)
  );
  iasc_exec_model u_iasc_exec_model (
    .clk_i(clk_i), .mem_req_o(mem_req), .alu_req_o(alu_req), .sys_evt_o(sys_evt),
    .pc_step_o(pc_step), .tbl_read_o(tbl_read), .tbl_word_o(tbl_word),
    .rd_valid_i(rd_valid), .rd_data_i(rd_data), .tbl_addr_i(tbl_addr)
  );

  // Clock, 10 ns period
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Short forms of the model's accesses
  task automatic wr(input logic [1:0] s, input logic [7:0] a, input logic [7:0] d);
    u_iasc_exec_model.wr(s, a, d, 1'b0);
  endtask
  task automatic rd_chk(input logic [1:0] s, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_iasc_exec_model.rd(s, a, v);
    `CHK(v, e)
  endtask

  // Watchdog against a hang
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    `CHK(flags, 8'h00)
    // Pointers, windows and sectors
    wr(2'h0, `IASC_OFS_PA_H, 8'h01);
    wr(2'h0, `IASC_OFS_PA_L, 8'h40);
    wr(2'h0, `IASC_OFS_PTR0, 8'h40);
    rd_chk(2'h0, `IASC_OFS_PA_H, 8'h01);
    rd_chk(2'h0, `IASC_OFS_PTR0, 8'h40);
    wr(2'h0, `IASC_OFS_IND1, 8'hAA);
    wr(2'h0, `IASC_OFS_IND0, 8'h55);
    rd_chk(2'h1, 8'h40, 8'hAA);
    rd_chk(2'h0, 8'h40, 8'h55);
    wr(2'h2, 8'h40, 8'h3C);
    wr(2'h0, `IASC_OFS_PA_H, 8'h02);
    rd_chk(2'h0, `IASC_OFS_IND1, 8'h3C);
    // Window aimed at another window
    wr(2'h0, `IASC_OFS_PB_L, `IASC_OFS_IND1);
    rd_chk(2'h0, `IASC_OFS_IND2, 8'h00);
    wr(2'h0, `IASC_OFS_IND2, 8'h99);
    rd_chk(2'h2, 8'h40, 8'h3C);
    // Pointer step through the ALU stays in its own register
    wr(2'h0, `IASC_OFS_PA_L, 8'hFF);
    wr(2'h0, `IASC_OFS_ACC, 8'h01);
    wr(2'h0, `IASC_OFS_FLG, 8'h00);
    u_iasc_exec_model.alu(iasc_pkg::iasc_op_add, 8'hFF, 1'b1, `IASC_OFS_PA_L);
    `CHK(acc, 8'h01)
    `CHK(flags, 8'h07)
    rd_chk(2'h0, `IASC_OFS_PA_L, 8'h00);
    rd_chk(2'h0, `IASC_OFS_PA_H, 8'h02);
    // Software keeps flags across a clobbering operation
    u_iasc_exec_model.rd(2'h0, `IASC_OFS_FLG, saved);
    u_iasc_exec_model.alu(iasc_pkg::iasc_op_xor, 8'h80, 1'b0, 8'h00);
    `CHK(flags, 8'h83)
    wr(2'h0, `IASC_OFS_FLG, saved);
    rd_chk(2'h0, `IASC_OFS_FLG, 8'h07);
    // Every ALU operation against its flags
    foreach (vecs[i]) begin
      wr(2'h0, `IASC_OFS_FLG, vecs[i].f0);
      wr(2'h0, `IASC_OFS_ACC, vecs[i].a);
      u_iasc_exec_model.alu(vecs[i].op, vecs[i].b, 1'b0, 8'h00);
      `CHK(acc, vecs[i].r)
      `CHK(flags, vecs[i].f)
    end
    // Watchdog and sleep flags
    wr(2'h0, `IASC_OFS_FLG, 8'h00);
    u_iasc_exec_model.evt(3'b100);
    `CHK(flags, 8'h20)
    wr(2'h0, `IASC_OFS_FLG, 8'hFF);
    `CHK(flags, 8'hEF)
    u_iasc_exec_model.evt(3'b001);
    `CHK(flags, 8'hDF)
    rd_chk(2'h0, `IASC_OFS_FLG, 8'hDF);
    u_iasc_exec_model.evt(3'b010);
    `CHK(flags, 8'hCF)
    // Program counter low jump inside the page
    u_iasc_exec_model.step(300);
    `CHK(pc, 13'h012C)
    wr(2'h0, `IASC_OFS_PCLO, 8'h34);
    `CHK(pc, 13'h0134)
    `CHK(dummy, 1'b1)
    @(posedge clk_i);
    #1;
    `CHK(dummy, 1'b0)
    // Table read after both pointers are set
    wr(2'h0, `IASC_OFS_TB_L, 8'h12);
    wr(2'h0, `IASC_OFS_TB_H, 8'h03);
    `CHK(tbl_addr, 16'h0312)
    u_iasc_exec_model.wr(2'h2, 8'h50, 8'h00, 1'b1);
    rd_chk(2'h2, 8'h50, 8'h3F);
    rd_chk(2'h0, `IASC_OFS_TB_B, 8'hB7);
    give_verdict();
  end
endmodule
